// ### rtl/adcphi_pkg.sv
// Shared constants and types for the ADC parallel host port.
// Assumes a single 250 MHz clock shared by both ends.
`default_nettype none
package adcphi_pkg;
  localparam int unsigned DATA_W       = 12;
  localparam int unsigned CFG_W        = 8;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Configuration byte field positions
  localparam int unsigned PCM_HI_POS   = 7;
  localparam int unsigned PCM_LO_POS   = 6;
  localparam int unsigned ACQ_POS      = 5;
  localparam int unsigned INCFG_POS    = 4;
  localparam int unsigned POL_POS      = 3;
  // Power and clock mode encodings
  localparam logic [1:0] PCM_FULL_PD   = 2'h0;
  localparam logic [1:0] PCM_STANDBY   = 2'h1;
  localparam logic [1:0] PCM_NORM_INT  = 2'h2;
  localparam logic [1:0] PCM_NORM_EXT  = 2'h3;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  // Timing: internal acquisition, conversion length, strobe pulse width
  localparam int unsigned ACQ_NS       = 1000;
  localparam int unsigned ACQ_CYC      = ACQ_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_STEPS   = 12;
  localparam int unsigned INT_DIV      = 16;
  localparam int unsigned STROBE_NS    = 100;
  localparam int unsigned STROBE_CYC   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_DIV      = 24;
  // Host register offsets over AXI4-Lite
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_RESULT    = 4'h8;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ACQ = 3'b001, ST_CONV = 3'b011, ST_DONE = 3'b010
  } adcphi_dev_st_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_WR = 3'b001, HS_WAIT = 3'b011, HS_RD = 3'b010, HS_GAP = 3'b110
  } adcphi_host_st_t;
endpackage
`default_nettype wire

// ### rtl/adcphi_if.sv
// Pin bundle between the ADC device end and the host end.
// Resolves three-state wires from output enables; pull-ups model idle levels.
`default_nettype none
interface adcphi_if;
  import adcphi_pkg::*;
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic              conv_clk;
  logic [DATA_W-1:0] dev_d_o;
  logic [DATA_W-1:0] dev_d_oe;
  logic [CFG_W-1:0]  host_d_o;
  logic              host_d_oe;
  logic              done_n_o;
  logic              done_n_oe;
  wire  [DATA_W-1:0] d_bus;
  wire               done_n;
  // Wire resolution, pull-up when undriven
  for (genvar i = 0; i < DATA_W; i++) begin : g_d
    if (i < CFG_W) begin : g_lo
      assign d_bus[i] = dev_d_oe[i] ? dev_d_o[i] : (host_d_oe ? host_d_o[i] : 1'b1);
    end else begin : g_hi
      assign d_bus[i] = dev_d_oe[i] ? dev_d_o[i] : 1'b1;
    end
  end
  assign done_n = done_n_oe ? done_n_o : 1'b1;
  modport dev (input cs_n, rd_n, wr_n, conv_clk, d_bus,
               output dev_d_o, dev_d_oe, done_n_o, done_n_oe);
  modport host (input d_bus, done_n,
                output cs_n, rd_n, wr_n, conv_clk, host_d_o, host_d_oe);
endinterface
`default_nettype wire

// ### rtl/adcphi_device.sv
// Device end: configuration capture, acquisition/conversion sequencing, readout.
// Assumes host strobes synchronous to aclk; analog result supplied on sample_data.
// No reset pin on the port: aresetn stands in for power-up; outputs float while deselected.
`default_nettype none
module adcphi_device
  import adcphi_pkg::*;
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  adcphi_if.dev                              pins,
  input  wire logic [adcphi_pkg::DATA_W-1:0] sample_data,
  output logic      [1:0]                    power_clock_mode_sel,
  output logic                               acquisition_mode_sel,
  output logic                               input_config_sel,
  output logic                               polarity_sel,
  output logic                               converting,
  output logic                               result_ready
);
  import adcphi_pkg::*;

  adcphi_dev_st_t    st_q;
  logic [CFG_W-1:0]  cfg_q;
  logic [DATA_W-1:0] result_q;
  logic              wr_n_q;
  logic              rd_n_q;
  logic              cclk_q;
  logic              done_q;
  logic              rd_act_q;
  logic [15:0]       cnt_q;
  logic [3:0]        step_q;
  logic              wr_rise;
  logic              rd_fall;
  logic              sel;
  logic              ext_clk;
  logic              step_tick;
  logic              start_req;
  logic              last_tick;

  // Strobe edge detection, qualified by chip select
  assign sel     = ~pins.cs_n;
  assign wr_rise = sel & pins.wr_n & ~wr_n_q;
  assign rd_fall = sel & ~pins.rd_n & rd_n_q;
  assign ext_clk = (cfg_q[PCM_HI_POS:PCM_LO_POS] == PCM_NORM_EXT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      cclk_q <= 1'b0;
    end else begin
      wr_n_q <= pins.wr_n;
      rd_n_q <= pins.rd_n;
      cclk_q <= pins.conv_clk;
    end
  end

  // Conversion step pacing: host clock falls, or internal divider
  always_comb begin
    if (ext_clk) begin
      step_tick = cclk_q & ~pins.conv_clk;
    end else begin
      step_tick = (cnt_q == 16'(INT_DIV - 1));
    end
  end

  // Configuration capture on write rising edge, except in ST_ACQ
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_rise && st_q != ST_ACQ) begin
      cfg_q <= pins.d_bus[CFG_W-1:0];
    end
  end

  // Last conversion step: the tick that completes the final step
  function automatic logic last_step(input logic [3:0] step, input logic tick);
    return tick && (step == 4'(CONV_STEPS - 1));
  endfunction

  // Start decode: power-down bytes configure but start nothing
  assign start_req = wr_rise & pins.d_bus[PCM_HI_POS];
  assign last_tick = last_step(step_q, step_tick);

  // Sequencer state: acquisition, conversion, done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE, ST_DONE: begin
          if (start_req) begin
            st_q <= ST_ACQ;
          end
        end
        // Internal acquisition times out; external waits for the next write rise
        ST_ACQ: begin
          if (acquisition_mode_sel ? wr_rise : (cnt_q == 16'h0000)) begin
            st_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (last_tick) begin
            st_q <= ST_DONE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Interval counter: acquisition countdown, then internal step divider
  // Kept apart per state so the two uses never fight over one count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        ST_IDLE, ST_DONE: begin
          cnt_q <= 16'(ACQ_CYC - 1);
        end
        ST_ACQ: begin
          if (acquisition_mode_sel || cnt_q == 16'h0000) begin
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_CONV: begin
          if (step_tick || ext_clk) begin
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  // Conversion step counter, cleared outside conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= 4'h0;
    end else if (st_q != ST_CONV) begin
      step_q <= 4'h0;
    end else if (step_tick) begin
      step_q <= step_q + 4'h1;
    end
  end

  // Result latch and completion flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 12'h000;
      done_q   <= 1'b0;
    end else if (st_q == ST_CONV && last_tick) begin
      result_q <= sample_data;
      done_q   <= 1'b1;
    end else if (rd_fall) begin
      done_q   <= 1'b0;
    end
  end

  // Read window: data driven from read fall until read rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_act_q <= 1'b0;
    end else if (pins.cs_n || pins.rd_n) begin
      rd_act_q <= 1'b0;
    end else if (rd_fall) begin
      rd_act_q <= 1'b1;
    end
  end

  // Pin drivers: low byte released while host writes
  assign pins.dev_d_o   = result_q;
  assign pins.dev_d_oe  = {DATA_W{rd_act_q & sel}};
  assign pins.done_n_o  = ~done_q;
  assign pins.done_n_oe = sel;

  // Decoded configuration fields
  assign power_clock_mode_sel = cfg_q[PCM_HI_POS:PCM_LO_POS];
  assign acquisition_mode_sel = cfg_q[ACQ_POS];
  assign input_config_sel     = cfg_q[INCFG_POS];
  assign polarity_sel         = cfg_q[POL_POS];
  assign converting           = (st_q == ST_CONV) || (st_q == ST_ACQ);
  assign result_ready         = done_q;
endmodule
`default_nettype wire

// ### rtl/adcphi_host.sv
// Host end: AXI4-Lite slave registers driving the parallel strobes.
// Assumes the device end shares aclk; pins reach it through adcphi_if.
`default_nettype none
module adcphi_host
  import adcphi_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  adcphi_if.host           pins,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import adcphi_pkg::*;

  adcphi_host_st_t   st_q;
  logic [CFG_W-1:0]  cfg_q;
  logic              start_q;
  logic              ext_clk_q;
  logic [DATA_W-1:0] res_q;
  logic              valid_q;
  logic [7:0]        tcnt_q;
  logic [7:0]        div_q;
  logic              cclk_q;
  logic              aw_q, w_q;
  logic [3:0]        awa_q;
  logic [31:0]       wd_q;
  logic              wst_q;
  logic              wr_fire;

  // Write channel capture, address and data in either order
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign wr_fire       = aw_q & w_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awa_q        <= 4'h0;
      wd_q         <= 32'h0000_0000;
      wst_q        <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q   <= 1'b1;
        wd_q  <= s_axi_wdata;
        wst_q <= s_axi_wstrb[0]; // Strobe is only valid with wvalid
      end
      if (wr_fire) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;

  // Control register: config byte, start bit 8, external clock bit 9
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= CFG_RST;
      start_q   <= 1'b0;
      ext_clk_q <= 1'b0;
    end else if (wr_fire && awa_q == REG_CTRL && wst_q) begin
      cfg_q     <= wd_q[7:0];
      start_q   <= wd_q[8];
      ext_clk_q <= wd_q[9];
    end else if (st_q == HS_WR) begin
      start_q <= 1'b0;
    end
  end

  // Read channel: one-cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata <= {22'h0, ext_clk_q, start_q, cfg_q};
        REG_STATUS: s_axi_rdata <= {29'h0, (st_q != HS_IDLE), ~pins.done_n, valid_q};
        REG_RESULT: s_axi_rdata <= {20'h0, res_q};
        default:    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_rresp   = 2'h0;

  // Free-running conversion clock divider, static low when internal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 8'h00;
      cclk_q <= 1'b0;
    end else if (!ext_clk_q) begin
      div_q  <= 8'h00;
      cclk_q <= 1'b0;
    end else if (div_q == 8'(EXT_DIV / 2 - 1)) begin
      div_q  <= 8'h00;
      cclk_q <= ~cclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign pins.conv_clk = cclk_q;

  // Strobe sequencer: write pulse, wait for flag, read pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= HS_IDLE;
      tcnt_q  <= 8'h00;
      res_q   <= 12'h000;
      valid_q <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          tcnt_q <= 8'h00;
          if (start_q) begin
            st_q    <= HS_WR;
            valid_q <= 1'b0;
          end
        end
        HS_WR: begin
          tcnt_q <= tcnt_q + 8'h01;
          if (tcnt_q == 8'(STROBE_CYC)) begin
            st_q   <= HS_WAIT;
            tcnt_q <= 8'h00;
          end
        end
        HS_WAIT: begin
          if (!pins.done_n) begin
            st_q <= HS_RD;
          end else if (start_q) begin
            st_q   <= HS_WR; // Second write ends an external acquisition
            tcnt_q <= 8'h00;
          end
        end
        HS_RD: begin
          tcnt_q <= tcnt_q + 8'h01;
          if (tcnt_q == 8'(STROBE_CYC)) begin
            res_q   <= pins.d_bus;
            valid_q <= 1'b1;
            st_q    <= HS_GAP;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Pin drive from the sequencer state
  assign pins.cs_n      = (st_q == HS_IDLE) || (st_q == HS_GAP);
  assign pins.wr_n      = ~((st_q == HS_WR) && tcnt_q < 8'(STROBE_CYC));
  assign pins.rd_n      = (st_q != HS_RD);
  assign pins.host_d_o  = cfg_q;
  assign pins.host_d_oe = (st_q == HS_WR);
endmodule
`default_nettype wire

// ### bench/adcphi_checker.sv
// Pin-level checks between the device end and the host end.
// Assumes one clock; the testbench instantiates it beside the pin bundle.
`default_nettype none
module adcphi_checker
  import adcphi_pkg::*;
(
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          cs_n,
  input wire logic                          rd_n,
  input wire logic                          wr_n,
  input wire logic [adcphi_pkg::DATA_W-1:0] dev_d_oe,
  input wire logic                          host_d_oe,
  input wire logic                          done_n_o,
  input wire logic                          done_n_oe,
  input wire logic [adcphi_pkg::DATA_W-1:0] d_bus,
  input wire logic                          done_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write rise with a byte that asks for a timed conversion
  sequence s_start_conv;
    $rose(wr_n) && !cs_n && $past(d_bus[PCM_HI_POS]) && !$past(d_bus[ACQ_POS]);
  endsequence
  // Write rise that must not start a conversion by itself
  sequence s_start_idle;
    $rose(wr_n) && !cs_n && (!$past(d_bus[PCM_HI_POS]) || $past(d_bus[ACQ_POS]));
  endsequence
  sequence s_read_fall;
    $fell(rd_n) && !cs_n;
  endsequence
  AST_CS_HI_DATA: assert property (cs_n && $past(cs_n) |-> dev_d_oe == '0) else $error("data driven");
  AST_CS_HI_FLAG: assert property (cs_n && $past(cs_n) |-> !done_n_oe) else $error("flag driven");
  AST_LINES_TOGETHER: assert property (dev_d_oe == '0 || dev_d_oe == '1) else $error("split enables");
  AST_NO_FIGHT: assert property (!(host_d_oe && |dev_d_oe)) else $error("bus contention");
  AST_READ_DRIVES: assert property (s_read_fall |=> dev_d_oe == '1) else $error("result not driven");
  AST_READ_FLAG_HI: assert property (s_read_fall |=> done_n_o && done_n_oe) else $error("flag stays low");
  AST_READ_AFTER_DONE: assert property ($fell(rd_n) |-> !done_n) else $error("read before done");
  AST_WR_HELD: assert property ($rose(wr_n) |=> wr_n[*8]) else $error("write strobe back low");
  AST_CONV_DONE: assert property (s_start_conv |=> done_n_o[*8] ##[1:1000] !done_n_o) else $error("no done");
  AST_NO_AUTO: assert property (s_start_idle |=> done_n_o[*8]) else $error("early done");
endmodule
`default_nettype wire

// ### bench/adc_parallel_host_interface_tb_top.sv
// Testbench: host end and device end joined by the pin bundle, driven over AXI4-Lite.
// Assumes the register map and timing of the package; one 250 MHz clock.
`default_nettype none
module adc_parallel_host_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcphi_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [DATA_W-1:0] sample_data = '0;
  logic [3:0]        awaddr = '0;
  logic [3:0]        araddr = '0;
  logic [3:0]        wstrb = '0;
  logic [31:0]       wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, pcm_sel;
  logic [31:0]       rdata;
  logic              acq_sel, incfg_sel, pol_sel, converting, result_ready;
  int                err_total = 0;
  int                checks_done = 0;
  int                done_lo_cnt = 0;
  // Clock at 4 ns
  always #2 aclk = ~aclk;
  adcphi_if u_adcphi_if ();
  adcphi_device u_adcphi_device (.aclk(aclk), .aresetn(aresetn), .pins(u_adcphi_if), .sample_data(sample_data),
    .power_clock_mode_sel(pcm_sel), .acquisition_mode_sel(acq_sel), .input_config_sel(incfg_sel),
    .polarity_sel(pol_sel), .converting(converting), .result_ready(result_ready));
  adcphi_host u_adcphi_host (.aclk(aclk), .aresetn(aresetn), .pins(u_adcphi_if), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  adcphi_checker u_adcphi_checker (.aclk(aclk), .aresetn(aresetn), .cs_n(u_adcphi_if.cs_n),
    .rd_n(u_adcphi_if.rd_n), .wr_n(u_adcphi_if.wr_n), .dev_d_oe(u_adcphi_if.dev_d_oe),
    .host_d_oe(u_adcphi_if.host_d_oe), .done_n_o(u_adcphi_if.done_n_o), .done_n_oe(u_adcphi_if.done_n_oe),
    .d_bus(u_adcphi_if.d_bus), .done_n(u_adcphi_if.done_n));
  // Edges at which the pin and the device output both show a finished conversion
  always @(posedge aclk) begin
    if (u_adcphi_if.done_n === 1'b0 && result_ready === 1'b1) begin
      done_lo_cnt <= done_lo_cnt + 1;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Reset held for 12 cycles
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_p, w_p, b_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b_p) begin
      @(posedge aclk);
      if (!aw_p && !w_p && bvalid) begin
        b_p = 1'b0;
        bready <= 1'b0;
        chk(bresp === 2'h0, "write response");
      end
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_p, r_p;
    @(posedge aclk);
    ar_p = 1'b1;
    r_p = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r_p) begin
      @(posedge aclk);
      if (!ar_p && rvalid) begin
        r_p = 1'b0;
        rready <= 1'b0;
        d = rdata;
        chk(rresp === 2'h0, "read response");
      end
      if (ar_p && arready) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
    end
  endtask
  // Idle pins float to pull-up; unmapped offset reads zero
  task automatic t_idle();
    logic [31:0] d;
    chk(u_adcphi_if.d_bus === 12'hFFF && u_adcphi_if.done_n === 1'b1, "pins not floating");
    axi_rd(4'hC, d);
    chk(d === 32'h0, "unmapped read");
  endtask
  // Full conversion: start, poll until finished, fetch and compare result and modes
  task automatic t_convert(input logic [7:0] cfg, input logic [11:0] smp, input logic ext);
    logic [31:0] d;
    logic        seen;
    int          n;
    int          lo0;
    sample_data <= smp;
    lo0 = done_lo_cnt;
    axi_wr(REG_CTRL, {22'h0, ext, 1'b1, cfg});
    if (cfg[ACQ_POS]) begin
      repeat (300) @(posedge aclk);
      chk(converting === 1'b1 && u_adcphi_if.done_n === 1'b1, "acquisition ended early");
      axi_wr(REG_CTRL, {22'h0, ext, 1'b1, cfg});
    end
    d = '0;
    seen = 1'b0;
    n = 0;
    while (!(seen && d[0] === 1'b1 && d[2] === 1'b0) && n < 600) begin
      axi_rd(REG_STATUS, d);
      seen = seen | (d[2] === 1'b1);
      n++;
    end
    chk(done_lo_cnt > lo0, "done flag not seen");
    axi_rd(REG_RESULT, d);
    chk(d[11:0] === smp, "result mismatch");
    chk(result_ready === 1'b0, "flag not returned high");
    chk(pcm_sel === cfg[7:6], "power mode");
    chk({acq_sel, incfg_sel, pol_sel} === cfg[5:3], "mode bits");
    chk(u_adcphi_if.cs_n === 1'b1 && u_adcphi_if.d_bus === 12'hFFF, "bus held");
    chk(ext || u_adcphi_if.conv_clk === 1'b0, "clock not static");
  endtask
  // Start that must not complete on its own; reset recovers the host
  task automatic t_stall(input logic [7:0] cfg);
    axi_wr(REG_CTRL, {23'h0, 1'b1, cfg});
    repeat (600) @(posedge aclk);
    chk(u_adcphi_if.done_n === 1'b1, "unexpected done");
    chk(pcm_sel === cfg[7:6] && acq_sel === cfg[5], "mode latch");
    chk(converting === cfg[7], "acquisition state");
    do_reset();
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_idle();
    t_convert(8'h80, 12'hA5C, 1'b0);
    t_convert(8'h98, 12'h5A3, 1'b0);
    t_convert(8'hC8, 12'hFFF, 1'b1);
    t_convert(8'hD0, 12'h001, 1'b1);
    t_stall(8'h00);
    t_stall(8'h58);
    t_stall(8'hA0);
    t_convert(8'hB8, 12'h3C6, 1'b0);
    t_convert(8'h88, 12'h800, 1'b0);
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
